// ### logic/asq_defines.svh
// constants for the area-scan acquisition sequencer
`ifndef ASQ_DEFINES_SVH
`define ASQ_DEFINES_SVH
// ----------------------------------------
// timing
// ----------------------------------------
`define ASQ_CLK_PERIOD_NS 40
`define ASQ_NS_PER_US 1000
`define ASQ_CYC_PER_US (`ASQ_NS_PER_US / `ASQ_CLK_PERIOD_NS)
`define ASQ_RATE_WINDOW_NS 1000000000
`define ASQ_RATE_WINDOW_CYC (`ASQ_RATE_WINDOW_NS / `ASQ_CLK_PERIOD_NS)
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ASQ_OFS_CTRL 8'h00
`define ASQ_OFS_MODE 8'h04
`define ASQ_OFS_SEQ_LEN 8'h08
`define ASQ_OFS_PHASE_LEN 8'h0C
`define ASQ_OFS_DELAY 8'h10
`define ASQ_OFS_SOFT 8'h14
`define ASQ_OFS_STATUS 8'h18
`define ASQ_OFS_DONE 8'h1C
`define ASQ_OFS_LEFT 8'h20
`define ASQ_OFS_RATE 8'h24
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ASQ_CTRL_RUN 0
`define ASQ_SOFT_FIRE 0
`define ASQ_MODE_HRM 0
`define ASQ_MODE_START_LSB 4
`define ASQ_MODE_NEXT_LSB 8
`define ASQ_NEXT_MAX 3'h4
`define ASQ_SEQ_LEN_RST 24'h000001
`define ASQ_PHASE_LEN_RST 8'h01
`define ASQ_DELAY_RST 16'h0000
`define ASQ_UNBOUNDED 24'hFFFFFF
`define ASQ_MAX_PHASES 17'h0FFFE
`endif

// ### logic/asq_delay_timer.sv
// microsecond delay between an accepted trigger and capture start
`timescale 1ns/100ps
module asq_delay_timer #(
  parameter int DELAY_W = 16,
  parameter int CYC_PER_US = 25
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic [DELAY_W-1:0] delay_us,
  output logic done
);
  localparam int PW = $clog2(CYC_PER_US + 1);
  logic running;
  logic [DELAY_W-1:0] us_left;
  logic [PW-1:0] pre;
  wire tick = pre == PW'(CYC_PER_US - 1);

  if (CYC_PER_US < 1) begin : g_bad
    $error("asq_delay_timer: CYC_PER_US must be at least 1");
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      running <= 1'b0;
      us_left <= '0;
      pre <= '0;
      done <= 1'b0;
    end else begin
      done <= running && us_left == '0;
      if (start) begin
        running <= 1'b1;
        us_left <= delay_us;
        pre <= '0;
      end else if (running) begin
        if (us_left == '0) begin
          running <= 1'b0;
        end else begin
          pre <= tick ? '0 : pre + 1'b1;
          if (tick) begin
            us_left <= us_left - 1'b1;
          end
        end
      end
    end
  end
endmodule

// ### logic/asq_pkg.sv
// types shared by the acquisition sequencer
package asq_pkg;
  typedef enum logic [1:0] {
    ASQ_ST_IMMEDIATE, ASQ_ST_HARD, ASQ_ST_SOFT, ASQ_ST_COMBINED
  } asq_start_e;
  typedef enum logic [2:0] {
    ASQ_NX_SAME, ASQ_NX_REPEAT, ASQ_NX_HARD, ASQ_NX_SOFT, ASQ_NX_COMBINED
  } asq_next_e;
  typedef enum logic [2:0] {
    ASQ_IDLE, ASQ_ARMED, ASQ_DELAY, ASQ_CAPTURE, ASQ_WAIT_NEXT
  } asq_state_e;
endpackage

// ### logic/asq_rate_meter.sv
// frames counted over a fixed window give the mean frame rate in frames/s
`timescale 1ns/100ps
module asq_rate_meter #(
  parameter int RATE_W = 24,
  parameter int WINDOW_CYC = 25000000
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic enable,
  input wire logic frame,
  output logic [RATE_W-1:0] rate
);
  logic [31:0] win;
  logic [RATE_W-1:0] cnt;
  wire win_end = win == 32'(WINDOW_CYC - 1);

  if (WINDOW_CYC < 2 || RATE_W < 21) begin : g_bad
    $error("asq_rate_meter: window too short or rate too narrow");
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn || clear) begin
      win <= '0;
      cnt <= '0;
      rate <= '0;
    end else if (enable) begin
      win <= win_end ? '0 : win + 1'b1;
      if (win_end) begin
        rate <= cnt + RATE_W'(frame);
        cnt <= '0;
      end else begin
        cnt <= cnt + RATE_W'(frame);
      end
    end
  end
endmodule

// ### logic/asq_sequencer.sv
// area-scan acquisition sequencer with its APB register file
// How it works
// - single-frame mode: one sequence per activation
// - single-frame mode is the reset default
// - single-frame: one sequence, then channel idles
// - single-frame: one frame per phase
// - start trigger select, defaults to immediate
// - next trigger select, defaults to same
// - single-frame length 1..65534 or unbounded
// - activation arms; first later trigger starts
// - programmable microsecond delay after every trigger
// - first trigger starts capture, flags sequence start
// - later triggers start capture, no flag
// - each single-frame phase fills one surface
// - manual stop ends only at frame boundary
// - finite length stops after last frame
// - unbounded length runs until forced idle
// - report done, remaining and mean rate
// - high-rate: phases of several frames per surface
// - high-rate keeps up with 1275000 frames/s
// - high-rate length 1..phase*65534 or unbounded
// - high-rate: next trigger starts every later frame
// - high-rate: one sequence, then channel idles
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/100ps
`include "asq_defines.svh"
module asq_sequencer
  import asq_pkg::*;
#(
  parameter int SEQ_W = 24,
  parameter int PHASE_W = 8,
  parameter int DELAY_W = 16,
  parameter int RATE_W = 24,
  parameter int RATE_WINDOW_CYC = `ASQ_RATE_WINDOW_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hard_trigger,
  input wire logic frame_done,
  output logic capture_start,
  output logic surface_done,
  output logic seq_start_event,
  output logic channel_active
);
  if (SEQ_W != 24 || PHASE_W != 8 || DELAY_W < 1 || DELAY_W > 32) begin : g_bad
    $error("asq_sequencer: unsupported width");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  asq_state_e state;
  asq_start_e start_sel;
  asq_next_e next_sel;
  logic hrm_mode;
  logic [SEQ_W-1:0] seq_len;
  logic [PHASE_W-1:0] phase_len;
  logic [DELAY_W-1:0] delay_us;
  logic [SEQ_W-1:0] done_cnt;
  logic [PHASE_W-1:0] phase_cnt;
  logic stop_req;
  logic seq_started;
  logic comb_armed;
  logic hard_prev;
  logic delay_done;
  logic [RATE_W-1:0] rate_raw;
  asq_start_e kind;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire hit_ctrl = paddr == `ASQ_OFS_CTRL;
  wire hit_mode = paddr == `ASQ_OFS_MODE;
  wire hit_seq = paddr == `ASQ_OFS_SEQ_LEN;
  wire hit_phase = paddr == `ASQ_OFS_PHASE_LEN;
  wire hit_delay = paddr == `ASQ_OFS_DELAY;
  wire hit_soft = paddr == `ASQ_OFS_SOFT;
  wire hit_stat = paddr == `ASQ_OFS_STATUS;
  wire hit_done = paddr == `ASQ_OFS_DONE;
  wire hit_left = paddr == `ASQ_OFS_LEFT;
  wire hit_rate = paddr == `ASQ_OFS_RATE;
  wire hit_cfg = hit_mode | hit_seq | hit_phase | hit_delay;
  wire mapped = hit_ctrl | hit_cfg | hit_soft | hit_stat | hit_done | hit_left | hit_rate;
  wire idle = state == ASQ_IDLE;
  wire [2:0] wr_next = pwdata[`ASQ_MODE_NEXT_LSB +: 3];
  wire [SEQ_W-1:0] wr_len = pwdata[SEQ_W-1:0];
  // longest finite sequence: 65534 phases of one or of frames_per_phase frames
  // both factors are widened first, a 17-bit product would wrap above 131071
  wire [24:0] max_len = hrm_mode ? 25'(phase_len) * 25'(`ASQ_MAX_PHASES)
                                 : 25'(`ASQ_MAX_PHASES);
  wire len_ok = (wr_len == `ASQ_UNBOUNDED) ||
                (wr_len != '0 && {1'b0, wr_len} <= max_len);
  // configuration is frozen while the channel runs so a sequence stays coherent
  wire bad_wr = (hit_cfg & ~idle) |
                (hit_mode & wr_next > `ASQ_NEXT_MAX) |
                (hit_seq & (~len_ok | |pwdata[31:SEQ_W])) |
                (hit_phase & (pwdata[PHASE_W-1:0] == '0 | |pwdata[31:PHASE_W]));
  wire wr_ok = wr & ~bad_wr;
  wire activate = wr_ok & hit_ctrl & pwdata[`ASQ_CTRL_RUN] & idle;
  wire halt_wr = wr_ok & hit_ctrl & ~pwdata[`ASQ_CTRL_RUN] & ~idle;
  wire soft_pulse = wr_ok & hit_soft & pwdata[`ASQ_SOFT_FIRE];

  assign pready = 1'b1;
  assign pslverr = acc & (~mapped | (pwrite & bad_wr));

  // ----------------------------------------
  // derived values
  // ----------------------------------------
  wire unbounded = seq_len == `ASQ_UNBOUNDED;
  wire [PHASE_W-1:0] eff_phase = hrm_mode ? phase_len : PHASE_W'(1);
  wire [SEQ_W-1:0] frames_left = unbounded ? '0 : seq_len - done_cnt;
  wire [RATE_W-1:0] mean_frame_rate = (seq_len > SEQ_W'(1)) ? rate_raw : '0;
  wire waiting = state == ASQ_ARMED || state == ASQ_WAIT_NEXT;
  wire hard_edge = hard_trigger & ~hard_prev;
  wire frame_in = state == ASQ_CAPTURE && frame_done;
  wire last_frame = !unbounded && done_cnt + 1'b1 == seq_len;
  wire phase_full = phase_cnt + 1'b1 == eff_phase;
  wire [SEQ_W-1:0] next_done = done_cnt + 1'b1;

  // the first frame obeys the start trigger, every later frame the next trigger
  always_comb begin
    kind = start_sel;
    if (seq_started) begin
      case (next_sel)
        ASQ_NX_SAME: kind = start_sel;
        ASQ_NX_REPEAT: kind = ASQ_ST_IMMEDIATE;
        ASQ_NX_HARD: kind = ASQ_ST_HARD;
        ASQ_NX_SOFT: kind = ASQ_ST_SOFT;
        ASQ_NX_COMBINED: kind = ASQ_ST_COMBINED;
        default: kind = start_sel;
      endcase
    end
  end

  // combined: a soft trigger arms, the next hard edge fires
  wire trig_hit = waiting && !stop_req &&
                  (kind == ASQ_ST_IMMEDIATE ||
                   (kind == ASQ_ST_HARD && hard_edge) ||
                   (kind == ASQ_ST_SOFT && soft_pulse) ||
                   (kind == ASQ_ST_COMBINED && hard_edge && comb_armed));

  assign channel_active = !idle;

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hrm_mode <= 1'b0;
      start_sel <= ASQ_ST_IMMEDIATE;
      next_sel <= ASQ_NX_SAME;
      seq_len <= `ASQ_SEQ_LEN_RST;
      phase_len <= `ASQ_PHASE_LEN_RST;
      delay_us <= `ASQ_DELAY_RST;
    end else if (wr_ok) begin
      if (hit_mode) begin
        hrm_mode <= pwdata[`ASQ_MODE_HRM];
        start_sel <= asq_start_e'(pwdata[`ASQ_MODE_START_LSB +: 2]);
        next_sel <= asq_next_e'(wr_next);
      end
      if (hit_seq) begin
        seq_len <= wr_len;
      end
      if (hit_phase) begin
        phase_len <= pwdata[PHASE_W-1:0];
      end
      if (hit_delay) begin
        delay_us <= pwdata[DELAY_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // read data, captured in the setup cycle
  // ----------------------------------------
  wire [31:0] status = {24'h000000, 1'b0, 3'(state), 1'b0, comb_armed, seq_started,
                        stop_req};
  wire [31:0] rd_mux =
    hit_ctrl ? {31'h00000000, !idle} :
    hit_mode ? {20'h00000, 1'b0, 3'(next_sel), 2'h0, 2'(start_sel), 3'h0, hrm_mode} :
    hit_seq ? 32'(seq_len) :
    hit_phase ? 32'(phase_len) :
    hit_delay ? 32'(delay_us) :
    hit_stat ? status :
    hit_done ? 32'(done_cnt) :
    hit_left ? 32'(frames_left) :
    hit_rate ? 32'(mean_frame_rate) : 32'h00000000;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // sequence control
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state <= ASQ_IDLE;
      done_cnt <= '0;
      phase_cnt <= '0;
      stop_req <= 1'b0;
      seq_started <= 1'b0;
      comb_armed <= 1'b0;
      hard_prev <= 1'b0;
      capture_start <= 1'b0;
      surface_done <= 1'b0;
      seq_start_event <= 1'b0;
    end else begin
      hard_prev <= hard_trigger;
      capture_start <= 1'b0;
      surface_done <= 1'b0;
      seq_start_event <= 1'b0;
      // an arming soft trigger in the same cycle as a firing one re-arms
      if (waiting && soft_pulse) begin
        comb_armed <= 1'b1;
      end else if (trig_hit || idle) begin
        comb_armed <= 1'b0;
      end
      if (halt_wr) begin
        stop_req <= 1'b1;
      end
      case (state)
        ASQ_IDLE: begin
          stop_req <= 1'b0;
          if (activate) begin
            state <= ASQ_ARMED;
            done_cnt <= '0;
            phase_cnt <= '0;
            seq_started <= 1'b0;
          end
        end
        ASQ_ARMED, ASQ_WAIT_NEXT: begin
          if (stop_req) begin
            state <= ASQ_IDLE;
          end else if (trig_hit) begin
            state <= ASQ_DELAY;
          end
        end
        ASQ_DELAY: begin
          if (stop_req) begin
            state <= ASQ_IDLE;
          end else if (delay_done) begin
            state <= ASQ_CAPTURE;
            capture_start <= 1'b1;
            seq_started <= 1'b1;
            seq_start_event <= !seq_started;
          end
        end
        ASQ_CAPTURE: begin
          // a stop request waits here for the frame to complete
          if (frame_done) begin
            done_cnt <= next_done;
            phase_cnt <= (phase_full || last_frame) ? '0 : phase_cnt + 1'b1;
            surface_done <= phase_full || last_frame || stop_req;
            // one sequence per activation: the last frame or a stop request drops the channel back to idle
            state <= (last_frame || stop_req) ? ASQ_IDLE : ASQ_WAIT_NEXT;
          end
        end
        default: state <= ASQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  asq_delay_timer #(
    .DELAY_W(DELAY_W),
    .CYC_PER_US(`ASQ_CYC_PER_US)
  ) u_delay (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .start(trig_hit),
    .delay_us(delay_us),
    .done(delay_done)
  );

  // at 25 MHz a 1275000 frames/s camera leaves about 19 cycles per frame
  asq_rate_meter #(
    .RATE_W(RATE_W),
    .WINDOW_CYC(RATE_WINDOW_CYC)
  ) u_rate (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clear(activate),
    .enable(!idle),
    .frame(frame_in),
    .rate(rate_raw)
  );

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_mode_default: assert property ($rose(resetn) |-> !hrm_mode)
    else $error("capture mode not single-frame after reset");
  a_start_default: assert property ($rose(resetn) |-> start_sel == ASQ_ST_IMMEDIATE)
    else $error("start trigger not immediate after reset");
  a_next_default: assert property ($rose(resetn) |-> next_sel == ASQ_NX_SAME)
    else $error("next trigger not same after reset");
  a_idle_ignores: assert property (idle && !activate |=> $stable(done_cnt) && !capture_start)
    else $error("idle channel moved a counter");
  a_arm_waits: assert property (state == ASQ_ARMED && !trig_hit && !stop_req
                                |=> state == ASQ_ARMED)
    else $error("sequence began without a trigger");
  a_first_flag: assert property ($rose(seq_started) |-> seq_start_event && capture_start)
    else $error("first capture without sequence start");
  a_later_quiet: assert property (capture_start && $past(seq_started) |-> !seq_start_event)
    else $error("sequence start flagged on a later phase");
  a_snap_surface: assert property (!hrm_mode && frame_in |=> surface_done)
    else $error("single-frame phase did not close its surface");
  a_auto_stop: assert property (frame_in && last_frame |=> idle && done_cnt == seq_len)
    else $error("finite sequence did not stop at its last frame");
  a_frame_bound: assert property (stop_req && state == ASQ_CAPTURE && !frame_done
                                  |=> state == ASQ_CAPTURE)
    else $error("manual stop cut a frame short");
  a_unbounded_on: assert property (unbounded && frame_in && !stop_req
                                   |=> state == ASQ_WAIT_NEXT)
    else $error("unbounded sequence stopped by itself");
  a_stop_waiting: assert property (stop_req && waiting |=> idle)
    else $error("stop while waiting did not idle the channel");
  a_single_phase: assert property (!hrm_mode && !idle |-> phase_cnt == '0)
    else $error("single-frame phase counted more than one frame");
  a_event_capture: assert property (seq_start_event |-> capture_start)
    else $error("sequence start without a capture start");
endmodule

// ### verification/asq_camera_model.sv
// camera and hardware trigger source facing the sequencer
`timescale 1ns/100ps
module asq_camera_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic capture_start,
  input wire logic trig_req,
  input wire logic [3:0] lat,
  output logic frame_done,
  output logic hard_trigger
);
  logic [4:0] cnt;
  logic hold;
  // frame_done follows capture_start by lat+2 cycles, so lat 1 gives a three-cycle frame
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cnt <= 5'h00;
      frame_done <= 1'b0;
    end else begin
      frame_done <= (cnt == 5'h01);
      if (capture_start) begin
        cnt <= {1'b0, lat} + 5'h01;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end
  // trigger line is held high two cycles, then driven back low
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      hold <= 1'b0;
      hard_trigger <= 1'b0;
    end else begin
      hold <= trig_req;
      hard_trigger <= trig_req | hold;
    end
  end
endmodule

// ### verification/tb.sv
// self-checking bench for the acquisition sequencer
`timescale 1ns/100ps
`include "asq_defines.svh"
module tb;
  typedef struct packed {logic rd; logic [31:0] data; logic err;} asq_note_s;
  localparam logic [7:0] R_CTRL = `ASQ_OFS_CTRL, R_MODE = `ASQ_OFS_MODE;
  localparam logic [7:0] R_SEQ = `ASQ_OFS_SEQ_LEN, R_PHASE = `ASQ_OFS_PHASE_LEN;
  localparam logic [7:0] R_DELAY = `ASQ_OFS_DELAY, R_SOFT = `ASQ_OFS_SOFT;
  localparam logic [7:0] R_STATUS = `ASQ_OFS_STATUS, R_DONE = `ASQ_OFS_DONE;
  localparam logic [7:0] R_LEFT = `ASQ_OFS_LEFT, R_RATE = `ASQ_OFS_RATE;
  localparam logic W = 1'b1, R = 1'b0, ERR = 1'b1;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, trig_req = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [3:0] cam_lat = 4'h1;
  logic pready, pslverr, hard_trigger, frame_done;
  logic capture_start, surface_done, seq_start_event, channel_active;
  int n_fail = 0, samples_checked = 0, n_cap = 0, n_sse = 0, n_surf = 0, n_frm = 0;
  int cyc = 0, t_cap = 0, t_acc = 0;
  asq_note_s exp_q[$];
  asq_note_s note;

  always #20 sys_clk = ~sys_clk;

  // short rate window keeps the run brief
  asq_sequencer #(.RATE_WINDOW_CYC(100)) DUT (.sys_clk(sys_clk), .resetn(resetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hard_trigger(hard_trigger),
    .frame_done(frame_done), .capture_start(capture_start), .surface_done(surface_done),
    .seq_start_event(seq_start_event), .channel_active(channel_active));
  asq_camera_model CAM (.sys_clk(sys_clk), .resetn(resetn), .capture_start(capture_start),
    .trig_req(trig_req), .lat(cam_lat), .frame_done(frame_done), .hard_trigger(hard_trigger));

  task automatic stop_test();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  // ----------------------------------------
  // monitor: event counts and apb answers
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cyc++;
    if (capture_start === 1'b1) begin
      n_cap++;
      t_cap = cyc;
    end
    if (seq_start_event === 1'b1) n_sse++;
    if (surface_done === 1'b1) n_surf++;
    if (frame_done === 1'b1) n_frm++;
    if (resetn && psel && penable && pready === 1'b1) begin
      t_acc = cyc;
      if (exp_q.size() == 0) begin
        chk("apb_note", 0, 1);
      end else begin
        note = exp_q.pop_front();
        chk("pslverr", {31'h0, note.err}, {31'h0, pslverr});
        if (note.rd) chk("prdata", note.data, prdata);
      end
    end
  end

  // for a read, d is the expected data
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic e = 1'b0);
    int n;
    exp_q.push_back('{rd: !w && !e, data: d, err: e});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? d : 32'h0;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (n >= 100) begin
      n_fail++;
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // counters are read at the falling edge, clear of the monitor's updates
  task automatic wait_cnt(ref int c, input int t);
    int n;
    n = 0;
    while (c < t && n < 3000) begin
      @(negedge sys_clk);
      n++;
    end
    if (c < t) begin
      n_fail++;
      stop_test();
    end
    @(posedge sys_clk);
  endtask

  // kind: 0 none, 1 hard edge, 2 soft write, 3 soft arm then hard edge
  task automatic fire(input int k);
    if (k >= 2) apb(R_SOFT, W, 32'h1);
    if (k == 1 || k == 3) begin
      trig_req <= 1'b1;
      @(posedge sys_clk);
      trig_req <= 1'b0;
      @(posedge sys_clk);
    end
  endtask

  task automatic run(input int st, input int nx, input int fr, input int sf);
    int c0, s0, f0, g0;
    c0 = n_cap;
    s0 = n_sse;
    f0 = n_surf;
    g0 = n_frm;
    cam_lat <= 4'($urandom_range(1, 8));
    apb(R_CTRL, W, 32'h1);
    for (int k = 0; k < fr; k++) begin
      fire(k == 0 || nx == 0 ? st : (nx == 1 ? 0 : nx - 1));
      wait_cnt(n_frm, g0 + k + 1);
    end
    @(posedge sys_clk);
    chk("channel_active", 32'h0, {31'h0, channel_active});
    chk("capture_start", fr, n_cap - c0);
    chk("seq_start_event", 1, n_sse - s0);
    chk("surface_done", sf, n_surf - f0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    int c;
    int fr;
    void'($urandom(14));
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    apb(R_CTRL, R, 0);
    apb(R_MODE, R, 0);
    apb(R_SEQ, R, 1);
    apb(R_PHASE, R, 1);
    apb(R_STATUS, R, 0);
    apb(8'h28, R, 0, ERR);
    apb(R_SEQ, W, 65535, ERR);
    apb(R_SEQ, W, 0, ERR);
    apb(R_PHASE, W, 256, ERR);
    apb(R_MODE, W, 32'h500, ERR);
    apb(R_SEQ, W, 65534);
    apb(R_SEQ, R, 65534);
    apb(R_MODE, W, 32'h10);
    apb(R_SEQ, W, 1);
    c = n_cap;
    fire(1);
    repeat (20) @(posedge sys_clk);
    chk("idle_capture", c, n_cap);
    run(1, 0, 1, 1);
    apb(R_MODE, W, 0);
    apb(R_DELAY, W, 2);
    run(0, 0, 1, 1);
    chk("trigger_delay", 4 + 2 * `ASQ_CYC_PER_US, t_cap - t_acc);
    apb(R_RATE, R, 0);
    apb(R_DONE, R, 1);
    apb(R_DELAY, W, 0);
    for (int i = 0; i < 5; i++) begin
      fr = $urandom_range(2, 4);
      apb(R_MODE, W, 32'((i << 8) | ((i % 4) << 4)));
      apb(R_SEQ, W, fr);
      run(i % 4, i, fr, fr);
      apb(R_DONE, R, fr);
      apb(R_LEFT, R, 0);
    end
    apb(R_MODE, W, 32'h101);
    apb(R_PHASE, W, 3);
    apb(R_SEQ, W, 3 * 65534);
    apb(R_SEQ, W, 3 * 65534 + 1, ERR);
    apb(R_SEQ, W, 5);
    run(0, 1, 5, 2);
    apb(R_MODE, W, 0);
    apb(R_SEQ, W, 2);
    run(0, 0, 2, 2);
    apb(R_MODE, W, 32'h100);
    apb(R_SEQ, W, 32'hFFFFFF);
    cam_lat <= 4'hF;
    c = n_frm;
    apb(R_CTRL, W, 32'h1);
    wait_cnt(n_frm, c + 5);
    apb(R_DELAY, W, 5, ERR);
    // lat 15 paces one frame per 21 cycles: four land in the first 100-cycle window
    apb(R_RATE, R, 4);
    apb(R_LEFT, R, 0);
    apb(R_CTRL, W, 0);
    chk("channel_active", 1, {31'h0, channel_active});
    c = n_frm;
    wait_cnt(n_frm, c + 1);
    @(posedge sys_clk);
    chk("channel_active", 0, {31'h0, channel_active});
    stop_test();
  end
endmodule
